// ==== rtl/uce_pkg.sv ====
// Constants, types and helpers shared by the command engine and its timer
package uce_pkg;

  // Clock and execution times
  localparam int CLK_PERIOD_NS    = 100;
  localparam int T_RST_HOLD_NS    = 30_000_000;
  localparam int T_RESET_ALL_NS   = 30_000_000;
  localparam int T_MODE_NS        = 10_000;
  localparam int T_ENDP_NS        = 2_000;
  localparam int T_RATE_MIN_NS    = 100_000;
  localparam int T_OTHER_NS       = 1_500;
  localparam int TMR_W            = 19;
  localparam logic [TMR_W-1:0] MODE_CYC  =
    TMR_W'((T_MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] ENDP_CYC  =
    TMR_W'((T_ENDP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] RATE_CYC  =
    TMR_W'((T_RATE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] OTHER_CYC =
    TMR_W'((T_OTHER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Buffer layout: ep0 and ep1 small, ep2 shared with the host pair
  localparam int             MEM_DEPTH = 80;
  localparam logic [6:0]     EP_SMALL  = 7'h08;
  localparam logic [6:0]     EP_BIG    = 7'h40;
  localparam logic [6:0]     EP1_BASE  = 7'h08;
  localparam logic [6:0]     EP2_BASE  = 7'h10;
  localparam logic [7:0]     EP1_IN_NUM  = 8'h81;
  localparam logic [7:0]     EP1_OUT_NUM = 8'h01;
  localparam logic [7:0]     EP2_IN_NUM  = 8'h82;
  localparam logic [7:0]     EP2_OUT_NUM = 8'h02;

  // Command codes (values arbitrary)
  localparam logic [7:0] CMD_GET_STATUS  = 8'h22;
  localparam logic [7:0] CMD_RESET_ALL   = 8'h05;
  localparam logic [7:0] CMD_SET_MODE    = 8'h15;
  localparam logic [7:0] CMD_ENDP_CFG    = 8'h1C;
  localparam logic [7:0] CMD_SERIAL_RATE = 8'h02;
  localparam logic [7:0] CMD_TOKEN_SEND  = 8'h4F;
  localparam logic [7:0] CMD_WR_EP0      = 8'h29;
  localparam logic [7:0] CMD_WR_EP1      = 8'h2A;
  localparam logic [7:0] CMD_WR_EP2      = 8'h2B;
  localparam logic [7:0] CMD_RD_DATA     = 8'h28;
  localparam logic [7:0] MODE_HOST_VAL   = 8'h06;
  localparam logic [7:0] ST_CMD_DONE     = 8'h14;
  localparam logic [7:0] RATE_RESET      = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IN   = 2'b01,
    ST_OUT  = 2'b10,
    ST_EXEC = 2'b11
  } uce_state_type;

  function automatic logic [6:0] ep_base(input logic [1:0] ep);
    ep_base = (ep == 2'd0) ? 7'h00 : (ep == 2'd1) ? EP1_BASE : EP2_BASE;
  endfunction

  function automatic logic [6:0] ep_size(input logic [1:0] ep);
    ep_size = (ep == 2'd2) ? EP_BIG : EP_SMALL;
  endfunction

endpackage

// ==== rtl/uce_tmr_if.sv ====
// Start and completion signals between command decoder and execution timer
interface uce_tmr_if;
  import uce_pkg::*;
  logic             start;
  logic [TMR_W-1:0] count;
  logic             busy;
  logic             done;
  modport ctrl (output start, output count, input busy, input done);
  modport tmr  (input start, input count, output busy, output done);
endinterface

// ==== rtl/uce_exec_timer.sv ====
// Execution timer: one done pulse a loaded number of cycles after start
module uce_exec_timer (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control
  uce_tmr_if.tmr    tmr
);
  import uce_pkg::*;

  logic [TMR_W-1:0] left_q;
  logic [TMR_W-1:0] elapsed_q;
  logic [TMR_W-1:0] target_q;
  logic             done_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_q <= '0;
      done_q <= 1'b0;
    end else if (tmr.start) begin
      left_q <= tmr.count;
      done_q <= 1'b0;
    end else begin
      done_q <= (left_q == TMR_W'(1));
      if (left_q != '0) begin
        left_q <= left_q - TMR_W'(1);
      end
    end
  end

  // Helper for checking the exact execution time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      elapsed_q <= '0;
      target_q  <= '0;
    end else if (tmr.start) begin
      elapsed_q <= '0;
      target_q  <= tmr.count;
    end else if (elapsed_q != {TMR_W{1'b1}}) begin
      elapsed_q <= elapsed_q + TMR_W'(1);
    end
  end

  assign tmr.busy = (left_q != '0);
  assign tmr.done = done_q;

  a_exact_exec_time: assert property (@(posedge clk_i) disable iff (rst_i)
    done_q |-> (elapsed_q == target_q))
    else $error("execution time differs from loaded count");

endmodule

// ==== rtl/uce_cmd_engine.sv ====
// Command interpreter and endpoint buffers behind the 8-bit controller port
module uce_cmd_engine #(
  parameter int unsigned RST_HOLD_CYC  = uce_pkg::T_RST_HOLD_NS / uce_pkg::CLK_PERIOD_NS,
  parameter int unsigned RESET_ALL_CYC = uce_pkg::T_RESET_ALL_NS / uce_pkg::CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Controller parallel port
  input  wire logic       cs_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       port_select_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_n_o,
  output logic            int_n_o,
  // Reset and clock status
  output logic            rst_busy_o,
  output logic            pll_run_o,
  // Serial engine receive side
  input  wire logic       usb_rx_valid_i,
  input  wire logic [1:0] usb_rx_ep_i,
  input  wire logic [7:0] usb_rx_data_i,
  input  wire logic       usb_rx_end_i,
  // Serial engine transmit side
  input  wire logic       usb_tx_rd_i,
  input  wire logic [1:0] usb_tx_ep_i,
  input  wire logic [5:0] usb_tx_idx_i,
  output logic      [7:0] usb_tx_data_o,
  output logic      [6:0] usb_tx_len_o,
  // Serial engine events and control
  input  wire logic       usb_evt_i,
  input  wire logic [7:0] usb_evt_code_i,
  output logic            usb_host_mode_o,
  output logic            token_req_o,
  output logic      [7:0] token_o,
  output logic      [7:0] ep_cfg_o,
  output logic     [15:0] serial_rate_o
);
  import uce_pkg::*;

  uce_tmr_if tmr_if ();

  logic [TMR_W-1:0] hold_q;
  logic             core_rst;
  logic             wr_act, rd_act;
  logic             wr_act_q, rd_act_q, wr_cmd_q, rd_cmd_q;
  logic [7:0]       wr_data_q;
  logic             wr_end, rd_end, cmd_take, in_take, out_take;
  uce_state_type    state_q;
  logic [7:0]       cmd_q;
  logic [6:0]       cnt_q, idx_q;
  logic             len_pend_q, rate_hi_q;
  logic [1:0]       sel_ep_q;
  logic [7:0]       out_byte_q;
  logic             host_q;
  logic [7:0]       up_mem [MEM_DEPTH];
  logic [7:0]       dn_mem [MEM_DEPTH];
  logic [6:0]       up_len_q [3];
  logic [1:0]       rx_ep, rx_ep_q;
  logic [6:0]       rx_wp_q, rx_len_q;
  logic             int_pend_q;
  logic [7:0]       int_stat_q;
  logic             status_cmd;
  logic             tstart_q;
  logic [TMR_W-1:0] tcount_q;
  logic [7:0]       data_q, tx_data_q, token_q, ep_cfg_q;
  logic [15:0]      rate_q;
  logic             token_req_q, rst_busy_q;

  // Internal reset stretch after external reset or full reset command
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_q <= TMR_W'(RST_HOLD_CYC);
    end else if (cmd_take && wr_data_q == CMD_RESET_ALL && !core_rst) begin
      hold_q <= TMR_W'(RESET_ALL_CYC);
    end else if (hold_q != '0) begin
      hold_q <= hold_q - TMR_W'(1);
    end
  end
  assign core_rst = sys_rst_i || (hold_q != '0);

  always_ff @(posedge clk_i) begin
    rst_busy_q <= core_rst;
  end
  assign rst_busy_o = rst_busy_q;
  // Multiplier for the serial engine reference runs only while neither external reset nor the reset stretch is active
  assign pll_run_o  = !rst_busy_q;

  // Strobe sampling; a byte is taken at the end of its strobe
  assign wr_act = !cs_n_i && !wr_n_i;
  assign rd_act = !cs_n_i && !rd_n_i && wr_n_i;
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      wr_act_q  <= 1'b0;
      rd_act_q  <= 1'b0;
      wr_cmd_q  <= 1'b0;
      rd_cmd_q  <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act) begin
        wr_data_q <= data_i;
        wr_cmd_q  <= port_select_i;
      end
      if (rd_act) begin
        rd_cmd_q <= port_select_i;
      end
    end
  end
  assign wr_end     = wr_act_q && !wr_act;
  assign rd_end     = rd_act_q && !rd_act;
  assign cmd_take   = wr_end && wr_cmd_q;
  assign in_take    = wr_end && !wr_cmd_q && (state_q == ST_IN);
  assign out_take   = rd_end && !rd_cmd_q && (state_q == ST_OUT);
  assign status_cmd = cmd_take && (wr_data_q == CMD_GET_STATUS);

  // Command sequencer
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      state_q    <= ST_IDLE;
      cmd_q      <= 8'h00;
      cnt_q      <= 7'h00;
      idx_q      <= 7'h00;
      len_pend_q <= 1'b0;
      rate_hi_q  <= 1'b0;
      sel_ep_q   <= 2'd0;
      out_byte_q <= 8'h00;
      tstart_q   <= 1'b0;
      tcount_q   <= '0;
    end else begin
      tstart_q <= 1'b0;
      if (cmd_take) begin
        cmd_q      <= wr_data_q;
        idx_q      <= 7'h00;
        len_pend_q <= 1'b0;
        rate_hi_q  <= 1'b0;
        state_q    <= ST_IN;
        cnt_q      <= 7'd1;
        case (wr_data_q)
          CMD_GET_STATUS: begin
            state_q    <= ST_OUT;
            out_byte_q <= int_stat_q;
          end
          CMD_SET_MODE, CMD_ENDP_CFG, CMD_SERIAL_RATE: begin
          end
          CMD_TOKEN_SEND: begin
            if (!host_q) begin
              state_q <= ST_IDLE;
            end
          end
          CMD_WR_EP0, CMD_WR_EP1, CMD_WR_EP2: begin
            sel_ep_q   <= wr_data_q[1:0] - 2'd1;
            len_pend_q <= 1'b1;
            if (host_q && wr_data_q != CMD_WR_EP2) begin
              state_q <= ST_IDLE;
            end
          end
          CMD_RD_DATA: begin
            state_q    <= ST_OUT;
            len_pend_q <= 1'b1;
            out_byte_q <= {1'b0, rx_len_q};
          end
          CMD_RESET_ALL: begin
            state_q <= ST_IDLE;
          end
          default: begin
            state_q  <= ST_EXEC;
            tstart_q <= 1'b1;
            tcount_q <= OTHER_CYC;
          end
        endcase
      end else if (in_take) begin
        case (cmd_q)
          CMD_SET_MODE: begin
            state_q  <= ST_EXEC;
            tstart_q <= 1'b1;
            tcount_q <= MODE_CYC;
          end
          CMD_ENDP_CFG: begin
            state_q  <= ST_EXEC;
            tstart_q <= 1'b1;
            tcount_q <= ENDP_CYC;
          end
          CMD_SERIAL_RATE: begin
            rate_hi_q <= 1'b1;
            if (rate_hi_q) begin
              state_q  <= ST_EXEC;
              tstart_q <= 1'b1;
              tcount_q <= RATE_CYC;
            end
          end
          CMD_TOKEN_SEND: begin
            state_q  <= ST_EXEC;
            tstart_q <= 1'b1;
            tcount_q <= OTHER_CYC;
          end
          default: begin
            if (len_pend_q) begin
              len_pend_q <= 1'b0;
              // Length clamps to the buffer size, never above 64
              cnt_q <= (wr_data_q[6:0] > ep_size(sel_ep_q) || wr_data_q[7])
                       ? ep_size(sel_ep_q) : wr_data_q[6:0];
              if (wr_data_q == 8'h00) begin
                state_q <= ST_IDLE;
              end
            end else begin
              idx_q <= idx_q + 7'd1;
              cnt_q <= cnt_q - 7'd1;
              if (cnt_q == 7'd1) begin
                state_q  <= ST_EXEC;
                tstart_q <= 1'b1;
                tcount_q <= OTHER_CYC;
              end
            end
          end
        endcase
      end else if (out_take) begin
        if (cmd_q == CMD_GET_STATUS) begin
          state_q <= ST_IDLE;
        end else if (len_pend_q) begin
          len_pend_q <= 1'b0;
          cnt_q      <= rx_len_q;
          out_byte_q <= dn_mem[ep_base(rx_ep_q)];
          idx_q      <= 7'd1;
          if (rx_len_q == 7'h00) begin
            state_q <= ST_IDLE;
          end
        end else begin
          cnt_q      <= cnt_q - 7'd1;
          out_byte_q <= dn_mem[ep_base(rx_ep_q) + idx_q];
          idx_q      <= idx_q + 7'd1;
          if (cnt_q == 7'd1) begin
            state_q  <= ST_EXEC;
            tstart_q <= 1'b1;
            tcount_q <= OTHER_CYC;
          end
        end
      end else if (state_q == ST_EXEC && tmr_if.done) begin
        state_q <= ST_IDLE;
      end
    end
  end

  assign tmr_if.start = tstart_q;
  assign tmr_if.count = tcount_q;

  uce_exec_timer u_timer (
    .clk_i (clk_i),
    .rst_i (core_rst),
    .tmr   (tmr_if.tmr)
  );

  // Settings taken from input bytes
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      host_q      <= 1'b0;
      ep_cfg_q    <= 8'h00;
      rate_q      <= {RATE_RESET, RATE_RESET};
      token_q     <= 8'h00;
      token_req_q <= 1'b0;
    end else begin
      token_req_q <= 1'b0;
      if (in_take) begin
        case (cmd_q)
          CMD_SET_MODE:    host_q <= (wr_data_q == MODE_HOST_VAL);
          CMD_ENDP_CFG:    ep_cfg_q <= wr_data_q;
          CMD_SERIAL_RATE: begin
            if (rate_hi_q) begin
              rate_q[15:8] <= wr_data_q;
            end else begin
              rate_q[7:0] <= wr_data_q;
            end
          end
          CMD_TOKEN_SEND: begin
            token_q     <= wr_data_q;
            token_req_q <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Upstream buffers; ep2 upstream is also the host output buffer
  always_ff @(posedge clk_i) begin
    if (in_take && !len_pend_q && cmd_q[7:2] == CMD_WR_EP0[7:2]) begin
      up_mem[ep_base(sel_ep_q) + idx_q] <= wr_data_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      up_len_q <= '{default: 7'h00};
    end else if (in_take && len_pend_q && cmd_q[7:2] == CMD_WR_EP0[7:2]) begin
      up_len_q[sel_ep_q] <= (wr_data_q[6:0] > ep_size(sel_ep_q) || wr_data_q[7])
                            ? ep_size(sel_ep_q) : wr_data_q[6:0];
    end
  end

  // Downstream buffers; ep2 downstream is also the host input buffer
  assign rx_ep = host_q ? 2'd2 : usb_rx_ep_i;
  always_ff @(posedge clk_i) begin
    if (usb_rx_valid_i && rx_wp_q < ep_size(rx_ep)) begin
      dn_mem[ep_base(rx_ep) + rx_wp_q] <= usb_rx_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      rx_wp_q  <= 7'h00;
      rx_len_q <= 7'h00;
      rx_ep_q  <= 2'd0;
    end else if (usb_rx_end_i) begin
      rx_wp_q  <= 7'h00;
      rx_len_q <= rx_wp_q;
      rx_ep_q  <= rx_ep;
    end else if (usb_rx_valid_i && rx_wp_q < ep_size(rx_ep)) begin
      rx_wp_q <= rx_wp_q + 7'd1;
    end
  end

  // Transmit read port for the serial engine
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      tx_data_q <= 8'h00;
    end else if (usb_tx_rd_i) begin
      tx_data_q <= up_mem[ep_base(usb_tx_ep_i) + {1'b0, usb_tx_idx_i}];
    end
  end
  assign usb_tx_data_o = tx_data_q;
  assign usb_tx_len_o  = (usb_tx_ep_i == 2'd3) ? 7'h00 : up_len_q[usb_tx_ep_i];

  // Interrupt: set by bus events and command completion, cleared by status query
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      int_pend_q <= 1'b0;
      int_stat_q <= 8'h00;
    end else if (usb_evt_i) begin
      int_pend_q <= 1'b1;
      int_stat_q <= usb_evt_code_i;
    end else if (state_q == ST_EXEC && tmr_if.done) begin
      int_pend_q <= 1'b1;
      int_stat_q <= ST_CMD_DONE;
    end else if (status_cmd) begin
      int_pend_q <= 1'b0;
    end
  end
  assign int_n_o = !int_pend_q;

  // Read data: status on the command port, buffered byte on the data port
  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      data_q <= 8'h00;
    end else begin
      data_q <= port_select_i ? {!int_pend_q, 7'h00} : out_byte_q;
    end
  end
  assign data_o      = data_q;
  assign data_oe_n_o = !rd_act;

  assign usb_host_mode_o = host_q;
  assign token_req_o     = token_req_q;
  assign token_o         = token_q;
  assign ep_cfg_o        = ep_cfg_q;
  assign serial_rate_o   = rate_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (core_rst);

  a_evt_raises_int: assert property (
    usb_evt_i |=> !int_n_o)
    else $error("bus event did not raise interrupt");

  a_int_held_low: assert property (
    (!int_n_o && !status_cmd) |=> !int_n_o)
    else $error("interrupt withdrawn without status query");

  a_int_released: assert property (
    (status_cmd && !usb_evt_i && !(state_q == ST_EXEC && tmr_if.done)) |-> ##[1:30] int_n_o)
    else $error("interrupt not withdrawn after status query");

  a_status_bit7: assert property (
    (port_select_i && !core_rst) |=> (data_o[7] == $past(int_n_o)))
    else $error("command port read bit 7 does not follow interrupt");

  a_mode_exec_time: assert property (
    (in_take && cmd_q == CMD_SET_MODE) |-> ##[100:200] tmr_if.done)
    else $error("mode selection time out of range");

  a_endp_exec_time: assert property (
    (in_take && cmd_q == CMD_ENDP_CFG) |-> ##[20:40] tmr_if.done)
    else $error("endpoint configuration time out of range");

  a_rate_min_time: assert property (
    (tstart_q && cmd_q == CMD_SERIAL_RATE) |-> (tcount_q >= 1000 && tcount_q <= 10000))
    else $error("serial rate execution time out of range");

  a_other_exec_time: assert property (
    (tstart_q && cmd_q == CMD_TOKEN_SEND) |-> ##[1:20] tmr_if.done)
    else $error("command execution exceeds 2 us");

  a_host_ep_refuse: assert property (
    (cmd_take && host_q && (wr_data_q == CMD_WR_EP0 || wr_data_q == CMD_WR_EP1))
      |=> state_q == ST_IDLE)
    else $error("port 1 write accepted in host mode");

  a_pkt_len_max: assert property (
    (in_take && len_pend_q) |=> cnt_q <= 7'd64)
    else $error("packet length above 64");

  a_reset_stretch: assert property (@(posedge clk_i) disable iff (1'b0)
    sys_rst_i |=> (hold_q == TMR_W'(RST_HOLD_CYC) && rst_busy_o))
    else $error("reset stretch not loaded");

endmodule

// ==== bench/uce_mcu_model.sv ====
// Controller-side model driving the 8-bit command and data port
module uce_mcu_model (
  // Clock
  input  wire logic       clk_i,
  // Port
  input  wire logic [7:0] bus_i,
  output logic            cs_n_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic            sel_o,
  output logic      [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  time  last_t = 0;
  logic cmd_q  = 1'b0;
  initial begin
    {cs_n_o, wr_n_o, rd_n_o, sel_o, data_o} = 12'hF00;
  end
  // One byte access; the gap after a command is longer than between data
  task automatic access(input logic s, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    while ($time - last_t < ((cmd_q || s) ? 1600 : 700)) begin
      @(negedge clk_i);
    end
    @(negedge clk_i);
    {cs_n_o, wr_n_o, rd_n_o, sel_o, data_o} = {1'b0, !w, w, s, d};
    repeat (2) @(negedge clk_i);
    q = bus_i;
    {cs_n_o, wr_n_o, rd_n_o} = 3'b111;
    data_o = ~d;
    cmd_q = s && w;
    last_t = $time;
  endtask
endmodule

// ==== bench/usb_host_command_engine_test.sv ====
// Self-checking bench for the command engine with random buffer traffic
module usb_host_command_engine_test;
  timeunit 1ns;
  timeprecision 1ns;
  import uce_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cs_n, wr_n, rd_n, sel, oe_n, int_n, busy, pll, hmode, treq;
  logic        rx_v = 0, rx_end = 0, tx_rd = 0, evt = 0;
  logic [1:0]  rx_ep = 0, tx_ep = 0;
  logic [5:0]  tx_idx = 0;
  logic [6:0]  tx_len;
  logic [7:0]  wd, dout, tx_d, tok, epc, q, tk, rx_d = 0, evt_code = 0;
  logic [15:0] rate;
  logic [31:0] seed = 32'hA4C1D928;
  logic [7:0]  buf_q [64];
  int          mismatches = 0;
  int          check_count = 0;
  int          n;
  int          treq_cnt = 0;
  always #50 clk_i = ~clk_i;
  // Counts cycles in which a token request is presented to the serial engine
  always @(posedge clk_i) begin
    if (treq === 1'b1) begin
      treq_cnt++;
    end
  end
  uce_cmd_engine #(.RST_HOLD_CYC(20), .RESET_ALL_CYC(20)) u_dut (
    .clk_i, .sys_rst_i, .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .port_select_i(sel), .data_i(wd), .data_o(dout), .data_oe_n_o(oe_n),
    .int_n_o(int_n), .rst_busy_o(busy), .pll_run_o(pll),
    .usb_rx_valid_i(rx_v), .usb_rx_ep_i(rx_ep), .usb_rx_data_i(rx_d),
    .usb_rx_end_i(rx_end), .usb_tx_rd_i(tx_rd), .usb_tx_ep_i(tx_ep),
    .usb_tx_idx_i(tx_idx), .usb_tx_data_o(tx_d), .usb_tx_len_o(tx_len),
    .usb_evt_i(evt), .usb_evt_code_i(evt_code), .usb_host_mode_o(hmode),
    .token_req_o(treq), .token_o(tok), .ep_cfg_o(epc), .serial_rate_o(rate));
  uce_mcu_model u_mcu (.clk_i, .bus_i(oe_n ? ~dout : dout), .cs_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .sel_o(sel), .data_o(wd));
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic s, input logic [7:0] d);
    u_mcu.access(s, 1'b1, d, q);
  endtask
  task automatic rd(input logic s);
    u_mcu.access(s, 1'b0, 8'h00, q);
  endtask
  task automatic waitfor(input logic e, input int lim);
    n = 0;
    while (busy !== e && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Completion within lo..hi cycles, then status query and clear
  task automatic done(input int lo, input int hi, input logic [7:0] code);
    n = 0;
    while (int_n !== 1'b0 && n < 20000) begin
      @(negedge clk_i);
      n++;
    end
    chk("exec time", 16'd1, 16'(n >= lo && n <= hi));
    rd(1'b1);
    chk("status bit", 16'h0000, 16'(q));
    wr(1'b1, CMD_GET_STATUS);
    n = 0;
    while (int_n !== 1'b1 && n < 30) begin
      @(negedge clk_i);
      n++;
    end
    chk("int cleared", 16'd1, 16'(int_n === 1'b1));
    rd(1'b0);
    chk("status code", 16'(code), 16'(q));
  endtask
  task automatic ep_fill(input logic [1:0] ep);
    int sz;
    sz = (ep == 2'd2) ? 64 : 8;
    wr(1'b1, CMD_WR_EP0 + 8'(ep));
    wr(1'b0, 8'hFF);
    for (int i = 0; i < sz; i++) begin
      buf_q[i] = rnd();
      wr(1'b0, buf_q[i]);
    end
    done(1, 20, ST_CMD_DONE);
    tx_ep = ep;
    @(negedge clk_i);
    chk("tx length", 16'(sz), 16'(tx_len));
    for (int i = 0; i < sz; i++) begin
      tx_idx = 6'(i);
      tx_rd = 1'b1;
      @(negedge clk_i);
      tx_rd = 1'b0;
      @(negedge clk_i);
      chk("tx byte", 16'(buf_q[i]), 16'(tx_d));
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (15) @(negedge clk_i);
    chk("held in reset", 16'h5, 16'({busy, pll, int_n}));
    waitfor(1'b0, 20);
    chk("reset end", 16'h1, 16'({busy, pll}));
    wr(1'b1, CMD_RESET_ALL);
    repeat (3) @(negedge clk_i);
    chk("reset all busy", 16'h1, 16'(busy));
    waitfor(1'b0, 40);
    chk("reset all end", 16'h0, 16'(busy));
    wr(1'b1, CMD_SET_MODE);
    wr(1'b0, 8'h00);
    done(1, 200, ST_CMD_DONE);
    wr(1'b1, CMD_ENDP_CFG);
    wr(1'b0, 8'h5A);
    done(1, 40, ST_CMD_DONE);
    chk("ep config", 16'h5A, 16'(epc));
    wr(1'b1, CMD_SERIAL_RATE);
    wr(1'b0, 8'h34);
    wr(1'b0, 8'h12);
    done(1000, 10000, ST_CMD_DONE);
    chk("serial rate", 16'h1234, rate);
    wr(1'b1, 8'hC3);
    done(1, 20, ST_CMD_DONE);
    tk = rnd();
    wr(1'b1, CMD_TOKEN_SEND);
    wr(1'b0, tk);
    repeat (40) @(negedge clk_i);
    chk("token refused", 16'h3, 16'({int_n, treq_cnt == 0}));
    for (int ep = 0; ep < 3; ep++) begin
      ep_fill(2'(ep));
    end
    wr(1'b1, CMD_SET_MODE);
    wr(1'b0, MODE_HOST_VAL);
    done(1, 200, ST_CMD_DONE);
    chk("host mode", 16'h1, 16'(hmode));
    wr(1'b1, CMD_WR_EP0);
    wr(1'b0, 8'h01);
    wr(1'b0, 8'h11);
    repeat (40) @(negedge clk_i);
    chk("refused", 16'h1, 16'(int_n));
    wr(1'b1, CMD_TOKEN_SEND);
    wr(1'b0, tk);
    done(1, 20, ST_CMD_DONE);
    chk("token", 16'(tk), 16'(tok));
    chk("token pulses", 16'd1, 16'(treq_cnt));
    ep_fill(2'd2);
    for (int i = 0; i < 64; i++) begin
      buf_q[i] = rnd();
      rx_d = buf_q[i];
      rx_v = 1'b1;
      @(negedge clk_i);
      rx_v = 1'b0;
      @(negedge clk_i);
    end
    rx_end = 1'b1;
    @(negedge clk_i);
    rx_end = 1'b0;
    wr(1'b1, CMD_RD_DATA);
    rd(1'b0);
    chk("rx length", 16'd64, 16'(q));
    for (int i = 0; i < 64; i++) begin
      rd(1'b0);
      chk("rx byte", 16'(buf_q[i]), 16'(q));
    end
    done(0, 20, ST_CMD_DONE);
    evt_code = rnd();
    evt = 1'b1;
    @(negedge clk_i);
    evt = 1'b0;
    done(0, 2, evt_code);
    conclude();
  end
  initial begin
    repeat (50000) @(negedge clk_i);
    mismatches++;
    conclude();
  end
endmodule
